// ---- hdl/lsf_throttle.sv ----
`timescale 1ns/1ps
// Contract
// - Only integer stores forward to integer loads
// - Forward needs equal size and address
// - Stores over eight bytes never forward
// - Address compare uses lowest twelve bits
// - Lines are sixteen four-byte chunks
// - Sub-word same-chunk different bytes add delay
// - Line-split load costs fourteen cycles; a split load held in ST_HOLD issues without the penalty
// - Non-zero segment base delays the operation
// - Unaligned base: one op per nine
// - Data segment aligned base: one per two
// - Auxiliary segments one per two unless base unaligned
// - Extra segment aligned base: string dest two, else nine
// - Code or stack aligned base: one per nine
// - Hazard makes long op stalling issue
// - Unforwardable overlapping load is delayed, reissued
module lsf_throttle
    import lsf_pkg::*;
(
    input wire logic ref_clk, // Core clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic req_valid, // Memory operation offered
    input wire logic req_is_load, // 1 load, 0 store
    input wire logic req_int, // Integer pipeline operation
    input wire logic [2:0] req_size, // Size code, log2 bytes
    input wire lsf_seg_e req_seg, // Segment used
    input wire logic req_str_dst, // String destination access
    input wire logic [31:0] req_addr, // Offset within segment
    input wire logic [63:0] req_data, // Store data
    input wire logic [5:0][31:0] seg_base, // Base of each segment
    output logic req_ready, // Operation may be offered
    output logic long_op, // Issue of later ops stalled
    output logic done_valid, // Operation issued, one cycle
    output logic done_fwd, // Load served by forwarding
    output logic [63:0] done_data, // Forwarded load data
    output logic cache_wr_valid, // Store written to cache, one cycle
    output logic [31:0] cache_wr_addr, // Cache write address
    output logic [2:0] cache_wr_size, // Cache write size code
    output logic [63:0] cache_wr_data // Cache write data
);
    // Whole state of the block
    typedef struct packed {
        lsf_st_e fsm; // Sequencer state
        logic ready; // Accepting
        logic long_op; // Hazard in progress
        logic [4:0] cnt; // Remaining delay
        logic [3:0] since; // Cycles since last issue
        logic done; // Issue pulse
        logic fwd; // Issue was forwarded
        logic [63:0] ddata; // Forwarded data
        logic p_load; // Pending is a load
        logic p_fwd; // Pending load forwards
        logic [3:0] p_gap; // Pending spacing
        logic [31:0] p_addr; // Pending address
        logic [2:0] p_size; // Pending size
        logic p_int; // Pending integer
        logic [63:0] p_data; // Pending data
        logic sb_valid; // Store buffer full
        logic [31:0] sb_addr; // Buffered store address
        logic [2:0] sb_size; // Buffered store size
        logic sb_int; // Buffered store integer
        logic [63:0] sb_data; // Buffered store data
        logic [1:0] sb_cnt; // Drain countdown
        logic wr_valid; // Cache write pulse
        logic [31:0] wr_addr; // Cache write address
        logic [2:0] wr_size; // Cache write size
        logic [63:0] wr_data; // Cache write data
        logic last_valid; // Previous access known
        logic [31:0] last_addr; // Previous access address
        logic [2:0] last_size; // Previous access size
    } lsf_state_s;

    lsf_state_s state_ff; // Registered state
    lsf_state_s nxt_state; // Next state
    lsf_fwd_if fwd_if (.clk(ref_clk), .rst(rst)); // Link to forward checker

    logic take; // Request accepted this cycle
    logic [31:0] lin_addr; // Linear address
    logic [3:0] gap_now; // Spacing for the request
    logic split; // Load crosses a line
    logic sub_hit; // Sub-word same-chunk conflict
    logic hold; // Must wait for the store buffer
    logic [4:0] wait_cyc; // Total added delay
    logic c_go; // Operation issues this cycle
    logic c_load; // Issuing op is a load
    logic c_fwd; // Issuing load forwards
    logic [3:0] c_gap; // Issuing op spacing
    logic [31:0] c_addr; // Issuing address
    logic [2:0] c_size; // Issuing size
    logic c_int; // Issuing integer
    logic [63:0] c_data; // Issuing data

    // Spacing demanded by segment and its base
    function automatic logic [3:0] seg_gap(input lsf_seg_e s, input logic [31:0] b,
                                           input logic str_dst);
        logic aux;
        aux = (s == SEG_AUX_SEGMENT_ONE) || (s == SEG_AUX_SEGMENT_TWO);
        if (b == 32'h0) begin
            seg_gap = aux ? GAP_FAST : GAP_NONE;
        end else if (b[LINE_OFS_W-1:0] != 6'h0) begin
            seg_gap = GAP_SLOW;
        end else begin
            case (s)
                SEG_DATA_SEGMENT: seg_gap = GAP_FAST;
                SEG_AUX_SEGMENT_ONE, SEG_AUX_SEGMENT_TWO: seg_gap = GAP_FAST;
                SEG_EXTRA_SEGMENT: seg_gap = str_dst ? GAP_FAST : GAP_SLOW;
                default: seg_gap = GAP_SLOW;
            endcase
        end
    endfunction

    // Request meets the buffered store
    always_comb begin
        fwd_if.st_valid = state_ff.sb_valid;
        fwd_if.st_addr = state_ff.sb_addr;
        fwd_if.st_size = state_ff.sb_size;
        fwd_if.st_int = state_ff.sb_int;
        fwd_if.ld_addr = lin_addr;
        fwd_if.ld_size = req_size;
        fwd_if.ld_int = req_int;
    end

    lsf_fwd_chk u_fwd_chk (
        .fi(fwd_if)
    );

    // Hazard and delay of the offered request
    always_comb begin
        take = req_valid && state_ff.ready;
        lin_addr = req_addr + seg_base[req_seg];
        gap_now = seg_gap(req_seg, seg_base[req_seg], req_str_dst);
        split = req_is_load
                && (line_of(lin_addr) != line_of(last_byte(lin_addr, req_size)));
        sub_hit = state_ff.last_valid && (req_size < WORD_SZ)
                  && (state_ff.last_size < WORD_SZ)
                  && (lin_addr[ADDR_W-1:CHUNK_LSB] == state_ff.last_addr[ADDR_W-1:CHUNK_LSB])
                  && (lin_addr[CHUNK_LSB-1:0] != state_ff.last_addr[CHUNK_LSB-1:0]);
        hold = req_is_load ? (fwd_if.overlap && !fwd_if.can_fwd)
                           : state_ff.sb_valid;
        wait_cyc = 5'h0;
        if (gap_now > state_ff.since) begin
            wait_cyc = {1'b0, gap_now - state_ff.since};
        end
        if (split) begin
            wait_cyc = wait_cyc + SPLIT_PEN_CYC;
        end
        if (sub_hit) begin
            wait_cyc = wait_cyc + SUBWORD_DLY_CYC;
        end
    end

    // Sequencer, store buffer and issue
    always_comb begin
        nxt_state = state_ff;
        nxt_state.done = 1'b0;
        nxt_state.wr_valid = 1'b0;
        c_go = 1'b0;
        c_load = state_ff.p_load;
        c_fwd = state_ff.p_fwd;
        c_gap = state_ff.p_gap;
        c_addr = state_ff.p_addr;
        c_size = state_ff.p_size;
        c_int = state_ff.p_int;
        c_data = state_ff.p_data;
        // Issue distance counter saturates
        if (state_ff.since != SINCE_MAX) begin
            nxt_state.since = state_ff.since + 4'h1;
        end
        // Buffered store drains into the cache
        if (state_ff.sb_valid) begin
            if (state_ff.sb_cnt == 2'h1) begin
                nxt_state.sb_valid = 1'b0;
                nxt_state.wr_valid = 1'b1;
                nxt_state.wr_addr = state_ff.sb_addr;
                nxt_state.wr_size = state_ff.sb_size;
                nxt_state.wr_data = state_ff.sb_data;
            end else begin
                nxt_state.sb_cnt = state_ff.sb_cnt - 2'h1;
            end
        end
        case (state_ff.fsm)
            ST_IDLE: begin
                if (take) begin
                    nxt_state.last_valid = 1'b1;
                    nxt_state.last_addr = lin_addr;
                    nxt_state.last_size = req_size;
                    c_load = req_is_load;
                    c_fwd = req_is_load && fwd_if.can_fwd;
                    c_gap = gap_now;
                    c_addr = lin_addr;
                    c_size = req_size;
                    c_int = req_int;
                    c_data = c_fwd ? state_ff.sb_data : req_data;
                    nxt_state.p_load = c_load;
                    nxt_state.p_fwd = c_fwd;
                    nxt_state.p_gap = c_gap;
                    nxt_state.p_addr = c_addr;
                    nxt_state.p_size = c_size;
                    nxt_state.p_int = c_int;
                    nxt_state.p_data = c_data;
                    if (hold) begin
                        // Load or store parks until the buffer empties
                        nxt_state.fsm = ST_HOLD;
                        nxt_state.ready = 1'b0;
                        nxt_state.long_op = 1'b1;
                    end else if (wait_cyc == 5'h0) begin
                        c_go = 1'b1;
                    end else begin
                        nxt_state.fsm = ST_WAIT;
                        nxt_state.cnt = wait_cyc;
                        nxt_state.ready = 1'b0;
                        nxt_state.long_op = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                // Count the added delay down
                if (state_ff.cnt == 5'h1) begin
                    c_go = 1'b1;
                end else begin
                    nxt_state.cnt = state_ff.cnt - 5'h1;
                end
            end
            ST_HOLD: begin
                // Reissue once the store is in the cache and spacing allows
                if (!state_ff.sb_valid && (state_ff.since >= state_ff.p_gap)) begin
                    c_go = 1'b1;
                end
            end
            default: begin
                nxt_state.fsm = ST_IDLE;
                nxt_state.ready = 1'b1;
                nxt_state.long_op = 1'b0;
            end
        endcase
        // Issue the operation
        if (c_go) begin
            nxt_state.fsm = ST_IDLE;
            nxt_state.ready = 1'b1;
            nxt_state.long_op = 1'b0;
            nxt_state.done = 1'b1;
            nxt_state.since = 4'h1;
            nxt_state.fwd = c_load && c_fwd;
            nxt_state.ddata = (c_load && c_fwd) ? c_data : 64'h0;
            if (!c_load) begin
                nxt_state.sb_valid = 1'b1;
                nxt_state.sb_addr = c_addr;
                nxt_state.sb_size = c_size;
                nxt_state.sb_int = c_int;
                nxt_state.sb_data = c_data;
                nxt_state.sb_cnt = DRAIN_CYC;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= '0;
            state_ff.fsm <= ST_IDLE;
            state_ff.ready <= 1'b1;
            state_ff.since <= SINCE_MAX;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state register
    assign req_ready = state_ff.ready;
    assign long_op = state_ff.long_op;
    assign done_valid = state_ff.done;
    assign done_fwd = state_ff.fwd;
    assign done_data = state_ff.ddata;
    assign cache_wr_valid = state_ff.wr_valid;
    assign cache_wr_addr = state_ff.wr_addr;
    assign cache_wr_size = state_ff.wr_size;
    assign cache_wr_data = state_ff.wr_data;

    property p_split_pen;
        @(posedge ref_clk) disable iff (rst)
        (take && split && !hold) |=> (!state_ff.done)[*8] ##1 (!state_ff.done)[*6];
    endproperty
    a_split_pen: assert property (p_split_pen) else $error("split load too early");

    property p_spacing;
        @(posedge ref_clk) disable iff (rst)
        c_go |-> (state_ff.since >= c_gap);
    endproperty
    a_spacing: assert property (p_spacing) else $error("issue spacing violated");

    property p_nonzero_base;
        @(posedge ref_clk) disable iff (rst)
        (take && seg_base[req_seg] != 32'h0) |-> (gap_now >= 4'h2);
    endproperty
    a_nonzero_base: assert property (p_nonzero_base) else $error("base not delayed");

    property p_extra_seg;
        @(posedge ref_clk) disable iff (rst)
        (take && req_seg == SEG_EXTRA_SEGMENT && seg_base[req_seg] != 32'h0
         && seg_base[req_seg][5:0] == 6'h0) |-> (gap_now == (req_str_dst ? 4'h2 : 4'h9));
    endproperty
    a_extra_seg: assert property (p_extra_seg) else $error("extra segment rate");

    property p_aux_zero;
        @(posedge ref_clk) disable iff (rst)
        (take && req_seg inside {SEG_AUX_SEGMENT_ONE, SEG_AUX_SEGMENT_TWO}
         && seg_base[req_seg] == 32'h0) |-> (gap_now == 4'h2);
    endproperty
    a_aux_zero: assert property (p_aux_zero) else $error("aux segment unthrottled");

    property p_long_op;
        @(posedge ref_clk) disable iff (rst)
        (take && (hold || wait_cyc != 5'h0)) |=> (long_op && !req_ready);
    endproperty
    a_long_op: assert property (p_long_op) else $error("hazard did not stall");

    property p_hold_load;
        @(posedge ref_clk) disable iff (rst)
        (take && req_is_load && hold) |=> (state_ff.fsm == ST_HOLD) && !done_valid;
    endproperty
    a_hold_load: assert property (p_hold_load) else $error("overlapping load not held");

    property p_hold_drain;
        @(posedge ref_clk) disable iff (rst)
        (state_ff.fsm == ST_HOLD && state_ff.sb_valid) |=> !done_valid;
    endproperty
    a_hold_drain: assert property (p_hold_drain) else $error("held load left early");
endmodule // lsf_throttle

// ---- hdl/lsf_pkg.sv ----
package lsf_pkg;
    // Address and data widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 64;
    // 64-byte line made of sixteen 4-byte chunks
    localparam int LINE_OFS_W = 6;
    localparam int CHUNK_LSB = 2;
    // Low address bits that the forwarding compare looks at
    localparam int ALIAS_W = 12;
    // Size codes are log2 of the byte count
    localparam logic [2:0] FWD_MAX_SZ = 3'h3;
    localparam logic [2:0] WORD_SZ = 3'h2;
    // Least spacing between memory operations, in cycles
    localparam logic [3:0] GAP_NONE = 4'h1;
    localparam logic [3:0] GAP_FAST = 4'h2;
    localparam logic [3:0] GAP_SLOW = 4'h9;
    localparam logic [3:0] SINCE_MAX = 4'hf;
    // Added delays, in cycles
    localparam logic [4:0] SPLIT_PEN_CYC = 5'he;
    localparam logic [4:0] SUBWORD_DLY_CYC = 5'h1;
    // Cycles a buffered store waits before its cache write
    localparam logic [1:0] DRAIN_CYC = 2'h3;

    // Segment selector of a memory operation
    typedef enum logic [2:0] {
        SEG_CODE = 3'h0,
        SEG_STACK = 3'h1,
        SEG_DATA_SEGMENT = 3'h2,
        SEG_EXTRA_SEGMENT = 3'h3,
        SEG_AUX_SEGMENT_ONE = 3'h4,
        SEG_AUX_SEGMENT_TWO = 3'h5
    } lsf_seg_e;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_HOLD = 3'b100
    } lsf_st_e;

    // Byte count of a size code
    function automatic logic [4:0] size_bytes(input logic [2:0] sz);
        return 5'h1 << sz;
    endfunction

    // Address of the last byte touched
    function automatic logic [ADDR_W-1:0] last_byte(input logic [ADDR_W-1:0] a,
                                                    input logic [2:0] sz);
        return a + {27'h0, size_bytes(sz)} - 32'h1;
    endfunction

    // Line number of an address
    function automatic logic [ADDR_W-LINE_OFS_W-1:0] line_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:LINE_OFS_W];
    endfunction
endpackage

// ---- hdl/lsf_fwd_if.sv ----
`timescale 1ns/1ps
// Store buffer entry against an incoming load, and the verdict
interface lsf_fwd_if (input logic clk, input logic rst);
    logic st_valid; // Buffered store present
    logic [31:0] st_addr; // Store address
    logic [2:0] st_size; // Store size code
    logic st_int; // Store from integer pipeline
    logic [31:0] ld_addr; // Load address
    logic [2:0] ld_size; // Load size code
    logic ld_int; // Load in integer pipeline
    logic overlap; // Low-bit byte ranges overlap
    logic can_fwd; // Store data may feed the load
    modport req (input clk, rst, overlap, can_fwd,
                 output st_valid, st_addr, st_size, st_int, ld_addr, ld_size, ld_int);
    modport chk (input clk, rst, st_valid, st_addr, st_size, st_int, ld_addr, ld_size,
                 ld_int, output overlap, can_fwd);
endinterface

// ---- hdl/lsf_fwd_chk.sv ----
`timescale 1ns/1ps
module lsf_fwd_chk
    import lsf_pkg::*;
(
    lsf_fwd_if.chk fi // Store and load to compare
);
    logic [ALIAS_W:0] st_lo; // Store first byte, low bits
    logic [ALIAS_W:0] st_hi; // Store last byte, low bits
    logic [ALIAS_W:0] ld_lo; // Load first byte, low bits
    logic [ALIAS_W:0] ld_hi; // Load last byte, low bits
    logic same_low; // Low address bits equal

    // Byte ranges use only the low address bits
    always_comb begin
        st_lo = {1'b0, fi.st_addr[ALIAS_W-1:0]};
        ld_lo = {1'b0, fi.ld_addr[ALIAS_W-1:0]};
        st_hi = st_lo + {8'h0, size_bytes(fi.st_size)} - 13'h1;
        ld_hi = ld_lo + {8'h0, size_bytes(fi.ld_size)} - 13'h1;
        same_low = (st_lo == ld_lo);
        fi.overlap = fi.st_valid && (ld_lo <= st_hi) && (st_lo <= ld_hi);
        // Integer only, equal size and address, at most 8 bytes
        fi.can_fwd = fi.overlap && fi.st_int && fi.ld_int
                     && (fi.st_size == fi.ld_size) && same_low
                     && (fi.st_size <= FWD_MAX_SZ);
    end

    property p_fwd_int;
        @(posedge fi.clk) disable iff (fi.rst)
        fi.can_fwd |-> (fi.st_int && fi.ld_int);
    endproperty
    a_fwd_int: assert property (p_fwd_int) else $error("fp or simd forward");

    property p_fwd_same;
        @(posedge fi.clk) disable iff (fi.rst)
        fi.can_fwd |-> (fi.st_size == fi.ld_size)
                       && (fi.st_addr[11:0] == fi.ld_addr[11:0]);
    endproperty
    a_fwd_same: assert property (p_fwd_same) else $error("forward size or addr differ");

    property p_fwd_wide;
        @(posedge fi.clk) disable iff (fi.rst)
        (fi.st_size > 3'h3) |-> !fi.can_fwd;
    endproperty
    a_fwd_wide: assert property (p_fwd_wide) else $error("wide store forwarded");

    property p_fwd_alias;
        @(posedge fi.clk) disable iff (fi.rst)
        (fi.st_valid && fi.st_int && fi.ld_int && fi.st_size == fi.ld_size
         && fi.st_size <= 3'h3 && fi.st_addr[11:0] == fi.ld_addr[11:0]) |-> fi.can_fwd;
    endproperty
    a_fwd_alias: assert property (p_fwd_alias) else $error("aliased load not matched");
endmodule // lsf_fwd_chk

// ---- sim/lsf_issue_model.sv ----
`timescale 1ns/1ps
// Issue stage model: streams queued ops, holds each until taken
module lsf_issue_model
    import lsf_pkg::*;
(
    input wire logic ref_clk, // Core clock
    input wire logic rst, // Synchronous reset
    input wire logic req_ready, // Block takes the offered op
    output logic req_valid, // Op offered
    output logic req_is_load, // 1 load
    output logic req_int, // Integer op
    output logic [2:0] req_size, // Size code
    output lsf_seg_e req_seg, // Segment
    output logic req_str_dst, // String destination
    output logic [31:0] req_addr, // Offset
    output logic [63:0] req_data // Store data
);
    // One queued op
    typedef struct packed {
        logic ld; logic in; logic [2:0] sz; lsf_seg_e sg;
        logic sd; logic [31:0] a; logic [63:0] d;
    } lsf_op_s;
    lsf_op_s q[$]; // Ops waiting
    lsf_op_s cur = '0; // Op on the lines
    // Fields of the current op onto the lines
    always_comb begin
        req_is_load = cur.ld;
        req_int = cur.in;
        req_size = cur.sz;
        req_seg = cur.sg;
        req_str_dst = cur.sd;
        req_addr = cur.a;
        req_data = cur.d;
    end
    // Queue an op
    function automatic void put(input logic ld, in, input logic [2:0] sz,
                                input lsf_seg_e sg, input logic sd, input logic [31:0] a,
                                input logic [63:0] d);
        q.push_back('{ld, in, sz, sg, sd, a, d});
    endfunction
    // Next op once taken; released address and data change every cycle
    always @(posedge ref_clk) begin
        if (rst) begin
            req_valid <= 1'b0;
        end else if (!req_valid || req_ready) begin
            if (q.size() > 0) begin
                cur <= q.pop_front();
                req_valid <= 1'b1;
            end else begin
                req_valid <= 1'b0;
                cur.a <= ~cur.a;
                cur.d <= ~cur.d;
            end
        end
    end
endmodule // lsf_issue_model

// ---- sim/test_load_store_forward_throttle.sv ----
`timescale 1ns/1ps
// Bench for the load/store throttle, fed by the issue model
module test_load_store_forward_throttle
    import lsf_pkg::*;
();
    logic ref_clk = 1'b0; // Core clock
    logic rst = 1'b1; // Reset
    logic [5:0][31:0] seg_base = '0; // Segment bases
    logic req_valid, req_is_load, req_int, req_str_dst, req_ready, long_op; // Handshake
    logic [2:0] req_size, cache_wr_size; // Size codes
    lsf_seg_e req_seg; // Segment of op
    logic [31:0] req_addr, cache_wr_addr; // Addresses
    logic [63:0] req_data, done_data, cache_wr_data; // Data
    logic done_valid, done_fwd, cache_wr_valid; // Pulses
    int err_count = 0, compares = 0, cyc = 0, n_long = 0; // Counters
    int t_take[$], t_done[$], t_wr[$]; // Event cycles
    logic d_fwd[$]; // Forward flags seen
    logic [63:0] d_data[$]; // Issue data seen
    // Clock
    always #12.5 ref_clk = ~ref_clk;
    lsf_issue_model iss_u (.ref_clk(ref_clk), .rst(rst), .req_ready(req_ready),
        .req_valid(req_valid), .req_is_load(req_is_load), .req_int(req_int),
        .req_size(req_size), .req_seg(req_seg), .req_str_dst(req_str_dst),
        .req_addr(req_addr), .req_data(req_data));
    lsf_throttle dut_u (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
        .req_is_load(req_is_load), .req_int(req_int), .req_size(req_size), .req_seg(req_seg),
        .req_str_dst(req_str_dst), .req_addr(req_addr), .req_data(req_data),
        .seg_base(seg_base), .req_ready(req_ready), .long_op(long_op),
        .done_valid(done_valid), .done_fwd(done_fwd), .done_data(done_data),
        .cache_wr_valid(cache_wr_valid), .cache_wr_addr(cache_wr_addr),
        .cache_wr_size(cache_wr_size), .cache_wr_data(cache_wr_data));
    // Record takes, issues, cache writes and stall cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (req_valid && req_ready) t_take.push_back(cyc);
        if (done_valid) begin
            t_done.push_back(cyc);
            d_fwd.push_back(done_fwd);
            d_data.push_back(done_data);
        end
        if (cache_wr_valid) t_wr.push_back(cyc);
        if (long_op) n_long++;
    end
    // Compare and count
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Counts, verdict, end of run
    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // New bases at an edge, records cleared between edges
    task automatic clr(input logic [5:0][31:0] b);
        @(posedge ref_clk);
        seg_base <= b;
        @(negedge ref_clk);
        t_take.delete();
        t_done.delete();
        t_wr.delete();
        d_fwd.delete();
        d_data.delete();
        n_long = 0;
    endtask
    // Wait for n issues, bounded, then let the store buffer drain
    task automatic run(input int n, input string name);
        int k;
        k = 0;
        while (t_done.size() < n && k < 300) begin
            @(posedge ref_clk);
            k++;
        end
        if (t_done.size() < n) begin
            chk("issue timeout", 0, 1);
            results();
        end
        repeat (20) @(posedge ref_clk);
        $display("test %s done", name);
    endtask
    // Op through the data segment, not a string destination
    function automatic void op(input logic ld, in, input logic [2:0] sz, input logic [31:0] a,
                               input logic [63:0] d);
        iss_u.put(ld, in, sz, SEG_DATA_SEGMENT, 1'b0, a, d);
    endfunction
    // Matching store and load forward; aliased low bits forward too
    task automatic t_fwd();
        clr('0);
        op(0, 1, 3'h3, 32'h100, 64'h1122334455667788);
        op(1, 1, 3'h3, 32'h100, 64'h0);
        op(0, 1, 3'h2, 32'h200, 64'hcafef00d);
        op(1, 1, 3'h2, 32'h1200, 64'h0);
        run(4, "forward");
        chk("fwd flag", d_fwd[1], 1'b1);
        chk("fwd data", d_data[1], 64'h1122334455667788);
        chk("alias fwd", d_fwd[3], 1'b1);
        chk("alias data", d_data[3], 64'hcafef00d);
        chk("wr addr", cache_wr_addr, 32'h200);
        chk("wr size", cache_wr_size, 3'h2);
        chk("wr data", cache_wr_data, 64'hcafef00d);
    endtask
    // Overlapping loads that may not forward wait for the cache write
    task automatic t_nofwd();
        logic si[4] = '{0, 1, 1, 1};
        logic li[4] = '{0, 0, 1, 1};
        logic [2:0] ss[4] = '{3'h3, 3'h3, 3'h2, 3'h4};
        logic [2:0] ls[4] = '{3'h3, 3'h3, 3'h3, 3'h4};
        for (int i = 0; i < 4; i++) begin
            clr('0);
            op(0, si[i], ss[i], 32'h300, 64'h5a5a);
            op(1, li[i], ls[i], 32'h300, 64'h0);
            run(2, "no forward");
            chk("no fwd", d_fwd[1], 1'b0);
            chk("no fwd data", d_data[1], 64'h0);
            chk("write seen", t_wr.size(), 1);
            chk("held past write", t_done[1] > t_wr[0], 1'b1);
            chk("stalled", n_long > 0, 1'b1);
        end
    endtask
    // Line-crossing load pays the split penalty under stall
    task automatic t_split();
        clr('0);
        op(1, 1, 3'h3, 32'h138, 64'h0);
        op(1, 1, 3'h3, 32'h13c, 64'h0);
        run(2, "split");
        chk("in-line latency", t_done[0] - t_take[0], 1);
        chk("split latency", t_done[1] - t_take[1], 15);
        chk("stall cycles", n_long, 14);
    endtask
    // Spacing of two loads for each segment and base kind
    task automatic t_gap();
        lsf_seg_e sg[9] = '{SEG_CODE, SEG_DATA_SEGMENT, SEG_DATA_SEGMENT, SEG_AUX_SEGMENT_ONE,
            SEG_AUX_SEGMENT_TWO, SEG_EXTRA_SEGMENT, SEG_EXTRA_SEGMENT, SEG_CODE, SEG_STACK};
        logic [31:0] bs[9] = '{0, 32'h40, 32'h44, 0, 0, 32'h40, 32'h40, 32'h40, 32'h80};
        logic sd[9] = '{0, 0, 0, 0, 0, 1, 0, 0, 0};
        int gp[9] = '{1, 2, 9, 2, 2, 2, 9, 9, 9};
        logic [5:0][31:0] b;
        for (int i = 0; i < 9; i++) begin
            b = '0;
            b[sg[i]] = bs[i];
            clr(b);
            iss_u.put(1, 1, 3'h2, sg[i], sd[i], 32'h400, 64'h0);
            iss_u.put(1, 1, 3'h2, sg[i], sd[i], 32'h408, 64'h0);
            run(2, "spacing");
            chk("spacing", t_done[1] - t_done[0], gp[i]);
        end
    endtask
    // Byte loads within one chunk, then across chunks
    task automatic t_sub();
        clr('0);
        op(1, 1, 3'h0, 32'h500, 64'h0);
        op(1, 1, 3'h0, 32'h503, 64'h0);
        op(1, 1, 3'h0, 32'h504, 64'h0);
        run(3, "sub-word");
        chk("same chunk", t_done[1] - t_done[0], 2);
        chk("next chunk", t_done[2] - t_done[1], 1);
    endtask
    // Reset, then each scenario
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("ready after reset", req_ready, 1'b1);
        chk("long after reset", long_op, 1'b0);
        t_fwd();
        t_nofwd();
        t_split();
        t_gap();
        t_sub();
        results();
    end
endmodule // test_load_store_forward_throttle
